// ==== bench/host_link_model.sv ====
`timescale 1ns/1ps
// Host end of the three-wire link; shift clock period 125 ns
module host_link_model (
    output logic select_load_strobe_o,
    output logic shift_clk_o,
    output logic serial_data_o
);
    // Idle link: strobe high, shift clock parked low
    initial begin
        select_load_strobe_o = 1'b1;
        shift_clk_o = 1'b0;
        serial_data_o = 1'b0;
    end

    // Sends the low n bits of w, first bit w[n-1]
    task automatic send(input logic [31:0] w, input int n);
        select_load_strobe_o <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_o <= w[i];
            #62.5 shift_clk_o <= 1'b1;
            #62.5 shift_clk_o <= 1'b0;
        end
        select_load_strobe_o <= 1'b1;
        serial_data_o <= ~w[0]; // Released line no longer shows the last bit
    endtask : send

    // Shift clock pulses while the strobe stays high
    task automatic stray(input int n);
        repeat (n) begin
            #62.5 shift_clk_o <= 1'b1;
            #62.5 shift_clk_o <= 1'b0;
        end
    endtask : stray
endmodule : host_link_model

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`include "dac_ctrl_regs.svh"
module tb_top
    import dac_ctrl_pkg::*;
;
    logic clk_i, reset_i, stb, sck, sdi, rd_i, wr_i, wait_o, dis_o, hz_o, sl;
    logic [4:0] addr_i;
    logic [31:0] wdata_i, rdata_o, rd;
    code_t out_a, out_b, ia, ib, oa, ob;
    int errors, n_checks, cycles;
    cmd_t rsv [8] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hb, 4'hc};

    dac_serial_ctrl i_dac_serial_ctrl (.clk_i(clk_i), .reset_i(reset_i),
        .select_load_strobe_i(stb), .shift_clk_i(sck), .serial_data_i(sdi),
        .avs_address_i(addr_i), .avs_read_i(rd_i), .avs_write_i(wr_i),
        .avs_writedata_i(wdata_i), .avs_readdata_o(rdata_o), .avs_waitrequest_o(wait_o),
        .channel_a_output_o(out_a), .channel_b_output_o(out_b),
        .analog_disable_o(dis_o), .high_z_o(hz_o));
    host_link_model i_host_link_model (.select_load_strobe_o(stb), .shift_clk_o(sck),
        .serial_data_o(sdi));

    // Clock and hang guard
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail("timeout");
            tally_and_finish();
        end
    end

    task automatic fail(input string m);
        errors++;
        $display("wrong value at %0t: %s", $time, m);
    endtask : fail

    task automatic chk10(input code_t g, input code_t e, input string m);
        n_checks++;
        if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
    endtask : chk10

    task automatic chk1(input logic g, input logic e, input string m);
        n_checks++;
        if (g !== e) fail($sformatf("%s got %b exp %b", m, g, e));
    endtask : chk1

    task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
        n_checks++;
        if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
    endtask : chk32

    // One Avalon transfer; held until waitrequest is sampled low
    task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        addr_i <= a;
        wr_i <= w;
        rd_i <= ~w;
        wdata_i <= d;
        do begin
            @(posedge clk_i);
            t++;
        end while (wait_o !== 1'b0 && t < 50);
        rd = rdata_o;
        if (t >= 50) fail("bus hang");
        rd_i <= 1'b0;
        wr_i <= 1'b0;
    endtask : av

    // Expected effect of one command
    task automatic model(input cmd_t c, input code_t k);
        if (c inside {4'h1, 4'h9, 4'hf}) ia = k;
        if (c inside {4'h2, 4'ha, 4'hf}) ib = k;
        if (c inside {4'h8, 4'h9, 4'ha, 4'hf}) begin
            oa = ia;
            ob = ib;
        end
        if (c == 4'he) sl = 1'b1;
        if (c inside {4'h8, 4'h9, 4'ha, 4'hd, 4'hf}) sl = 1'b0;
    endtask : model

    task automatic settle(input cmd_t c, input code_t k);
        repeat (12) @(posedge clk_i);
        model(c, k);
        chk10(out_a, oa, "out a");
        chk10(out_b, ob, "out b");
        chk1(dis_o, sl, "disable");
        chk1(hz_o, sl, "high z");
        av(1'b0, 5'(`OFS_IN_A), 32'h0);
        chk10(rd[9:0], ia, "in a");
        av(1'b0, 5'(`OFS_IN_B), 32'h0);
        chk10(rd[9:0], ib, "in b");
        av(1'b0, 5'(`OFS_OUT_A), 32'h0);
        chk10(rd[9:0], oa, "reg out a");
        av(1'b0, 5'(`OFS_OUT_B), 32'h0);
        chk10(rd[9:0], ob, "reg out b");
    endtask : settle

    task automatic link(input cmd_t c, input code_t k);
        i_host_link_model.send({16'h0, c, k, 2'b11}, 16);
        settle(c, k);
    endtask : link

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        clk_i = 1'b0;
        reset_i = 1'b1;
        {rd_i, wr_i, addr_i, wdata_i} = '0;
        {errors, n_checks, cycles} = '0;
        {ia, ib, oa, ob, sl} = '0;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        settle(4'h0, 10'h0);
        av(1'b0, 5'h1c, 32'h0);
        chk32(rd, `UNMAPPED_DATA, "unmapped");
        $display("test reset done");
        link(4'h1, 10'h3ff);
        link(4'h2, 10'h001);
        link(4'h8, 10'h155);
        $display("test load and update done");
        link(4'he, 10'h2aa);
        av(1'b0, 5'(`OFS_STATUS), 32'h0);
        chk1(rd[0], 1'b1, "status sleep");
        link(4'h1, 10'h0f0);
        link(4'h2, 10'h00f);
        link(4'hd, 10'h123);
        link(4'h8, 10'h000);
        $display("test sleep and wake done");
        link(4'h9, 10'h200);
        link(4'ha, 10'h011);
        link(4'hf, 10'h3c3);
        $display("test combined done");
        link(4'he, 10'h000);
        foreach (rsv[i]) link(rsv[i], 10'h3a5);
        link(4'hd, 10'h000);
        $display("test reserved done");
        i_host_link_model.send({12'h0, 4'he, 4'h9, 10'h2a7, 2'b11}, 20);
        settle(4'h9, 10'h2a7);
        i_host_link_model.stray(4);
        av(1'b0, 5'(`OFS_STATUS), 32'h0);
        chk32({23'h0, rd[8:0]}, {23'h0, 8'd20, sl}, "status count");
        av(1'b0, 5'(`OFS_COUNT), 32'h0);
        chk32(rd, {4'h9, 10'h2a7, 2'b11, 16'd22}, "link log");
        settle(4'h0, 10'h0);
        $display("test overlong and stray done");
        av(1'b1, 5'(`OFS_CTRL), {16'h0, 4'ha, 10'h099, 2'b00});
        settle(4'ha, 10'h099);
        av(1'b0, 5'(`OFS_CTRL), 32'h0);
        chk32(rd, {16'h0, 4'ha, 10'h099, 2'b00}, "ctrl readback");
        $display("test software word done");
        tally_and_finish();
    end
endmodule : tb_top

// ==== hw/dac_chan_regs.sv ====
`timescale 1ns/1ps
`include "dac_ctrl_regs.svh"
module dac_chan_regs
    import dac_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic exec_i,
    input wire logic [3:0] cmd_i,
    input wire logic [9:0] code_i,
    output code_t in_a_o,
    output code_t in_b_o,
    output code_t out_a_o,
    output code_t out_b_o,
    output logic sleep_o
);
    code_t in_a_ff, in_b_ff, out_a_ff, out_b_ff;
    logic sleep_ff;
    code_t nxt_in_a, nxt_in_b;
    logic load_a, load_b, update, wake, go_sleep;

    // Command decode; reserved codes fall through as no-operation
    assign load_a = exec_i && (cmd_i == `CMD_LOAD_A || cmd_i == `CMD_LOAD_A_UPD
        || cmd_i == `CMD_LOAD_ALL); // RL17 RL19 RL20
    assign load_b = exec_i && (cmd_i == `CMD_LOAD_B || cmd_i == `CMD_LOAD_B_UPD
        || cmd_i == `CMD_LOAD_ALL); // RL17 RL19 RL20
    assign update = exec_i && (cmd_i == `CMD_UPDATE || cmd_i == `CMD_LOAD_A_UPD
        || cmd_i == `CMD_LOAD_B_UPD || cmd_i == `CMD_LOAD_ALL); // RL18 RL21
    assign wake = update || (exec_i && cmd_i == `CMD_WAKE); // RL9 RL15 RL18
    assign go_sleep = exec_i && cmd_i == `CMD_SLEEP; // RL11 RL12
    assign nxt_in_a = load_a ? code_i : in_a_ff; // RL16
    assign nxt_in_b = load_b ? code_i : in_b_ff;

    // Input and output registers; outputs move only together
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            in_a_ff <= `CODE_RESET;
            in_b_ff <= `CODE_RESET;
            out_a_ff <= `CODE_RESET; // RL10
            out_b_ff <= `CODE_RESET; // RL10
            sleep_ff <= 1'b0;
        end else begin
            in_a_ff <= nxt_in_a; // RL7
            in_b_ff <= nxt_in_b;
            if (update) begin
                out_a_ff <= nxt_in_a; // RL8
                out_b_ff <= nxt_in_b; // RL8
            end
            if (go_sleep) begin
                sleep_ff <= 1'b1; // RL11
            end else if (wake) begin
                sleep_ff <= 1'b0; // RL14
            end
        end
    end

    assign in_a_o = in_a_ff;
    assign in_b_o = in_b_ff;
    assign out_a_o = out_a_ff;
    assign out_b_o = out_b_ff;
    assign sleep_o = sleep_ff;

    chk_outputs_paired: assert property (@(posedge clk_i) disable iff (reset_i) // RL8
        ($changed(out_a_ff) || $changed(out_b_ff)) |-> $past(update))
        else $error("output register changed without an update command");
    chk_sleep_keeps: assert property (@(posedge clk_i) disable iff (reset_i) // RL11
        $past(go_sleep) |-> sleep_ff && $stable(out_a_ff) && $stable(in_a_ff)
        && $stable(in_b_ff) && $stable(out_b_ff))
        else $error("sleep command altered registers");
    chk_load_no_wake: assert property (@(posedge clk_i) disable iff (reset_i) // RL15
        (exec_i && (cmd_i == `CMD_LOAD_A || cmd_i == `CMD_LOAD_B) && sleep_ff)
        |=> sleep_ff && $stable(out_a_ff))
        else $error("plain load woke the part or moved outputs");
    chk_reserved_nop: assert property (@(posedge clk_i) disable iff (reset_i) // RL21
        (exec_i && !(load_a || load_b || wake || go_sleep)) |=> $stable(in_a_ff)
        && $stable(in_b_ff) && $stable(sleep_ff) && $stable(out_a_ff) && $stable(out_b_ff))
        else $error("reserved command changed state");
    // After any transfer both outputs match their input registers
    chk_update_both: assert property (@(posedge clk_i) disable iff (reset_i) // RL8
        $past(update) |-> out_a_ff == in_a_ff && out_b_ff == in_b_ff)
        else $error("transfer did not move both channels");
    chk_load_all: assert property (@(posedge clk_i) disable iff (reset_i) // RL20
        (exec_i && cmd_i == `CMD_LOAD_ALL) |=> out_a_ff == $past(code_i)
        && out_b_ff == $past(code_i) && !sleep_ff)
        else $error("load all did not update both outputs");
endmodule : dac_chan_regs

// ==== hw/dac_ctrl_pkg.sv ====
package dac_ctrl_pkg;
    typedef logic [9:0] code_t;
    typedef logic [3:0] cmd_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01
    } link_state_t;
endpackage : dac_ctrl_pkg

// ==== hw/dac_ctrl_regs.svh ====
`ifndef DAC_CTRL_REGS_SVH
`define DAC_CTRL_REGS_SVH
// Operation
// RL1: A command word is sixteen bits: command, ten-bit code, two ignored pads.
// RL2: While strobe is low, data is sampled on each rising shift clock edge.
// RL3: Host sends command then code, each MSB first, pads last.
// RL4: Rising strobe executes the command held in the shift register.
// RL5: While strobe is high, shift clock edges are ignored.
// RL6: Host holds shift clock low when lowering the strobe.
// RL7: Each channel has a ten-bit input register and ten-bit output register.
// RL8: Inputs load singly or together; outputs always update together.
// RL9: One command may load, transfer and wake in a single strobe.
// RL10: Reset clears both output registers to code zero.
// RL11: Code 1110 sleeps; registers keep contents, analog disable asserted.
// RL12: The sleep command ignores its conversion code.
// RL13: While asleep, reference and outputs are high impedance.
// RL14: On waking, outputs not updated keep their pre-sleep value.
// RL15: 0001 and 0010 load without waking; 1000 wakes and transfers.
// RL16: Conversion code is unsigned k, output is k/1024 of reference.
// RL17: 0000 does nothing; 0001/0010 load input A/B only.
// RL18: 1000 transfers and wakes; 1101 only wakes; 1110 only sleeps.
// RL19: 1001/1010 load A/B, transfer both, and wake.
// RL20: 1111 loads both inputs with one code, transfers, wakes.
// RL21: Reserved codes do nothing.
// RL22: Extra bits shifted in: the last sixteen are used.

// Word layout
`define WORD_W 16
`define CMD_HI 15
`define CMD_LO 12
`define CODE_HI 11
`define CODE_LO 2
// Command codes
`define CMD_NOP 4'h0
`define CMD_LOAD_A 4'h1
`define CMD_LOAD_B 4'h2
`define CMD_UPDATE 4'h8
`define CMD_LOAD_A_UPD 4'h9
`define CMD_LOAD_B_UPD 4'ha
`define CMD_WAKE 4'hd
`define CMD_SLEEP 4'he
`define CMD_LOAD_ALL 4'hf
// Reset values
`define CODE_RESET 10'h000
// Avalon register byte offsets
`define OFS_CTRL 5'h00
`define OFS_STATUS 5'h04
`define OFS_IN_A 5'h08
`define OFS_IN_B 5'h0c
`define OFS_OUT_A 5'h10
`define OFS_OUT_B 5'h14
`define OFS_COUNT 5'h18
`define UNMAPPED_DATA 32'hdeadbeef
`endif

// ==== hw/dac_serial_ctrl.sv ====
`timescale 1ns/1ps
`include "dac_ctrl_regs.svh"
module dac_serial_ctrl
    import dac_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    // Three-wire link, asynchronous to clk_i, sampled on clk_i through synchronisers
    input wire logic select_load_strobe_i,
    input wire logic shift_clk_i,
    input wire logic serial_data_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Converter controls
    output logic [9:0] channel_a_output_o,
    output logic [9:0] channel_b_output_o,
    output logic analog_disable_o,
    output logic high_z_o
);
    // Synchronisers
    logic [1:0] cs_sync_ff, sck_sync_ff, din_sync_ff;
    logic cs_d_ff, sck_d_ff;
    logic [15:0] shift_ff;
    logic [15:0] nxt_shift;
    logic [7:0] bit_cnt_ff;
    link_state_t state_ff, nxt_state;
    logic cs_s, sck_s, din_s, sck_rise, cs_rise, cs_fall;
    logic link_exec, sw_exec, exec;
    logic [3:0] exec_cmd;
    logic [9:0] exec_code;
    logic [15:0] sw_word_ff;
    logic sw_go_ff;
    logic [15:0] last_word_ff;
    logic [15:0] word_count_ff;
    code_t in_a, in_b, out_a, out_b;
    logic sleep;
    logic ack_ff;
    logic [31:0] rd_data_ff, nxt_rd;
    logic bus_req;

    // Two-stage synchronisers for all link pins
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cs_sync_ff <= 2'h3;
            sck_sync_ff <= 2'h0;
            din_sync_ff <= 2'h0;
        end else begin
            cs_sync_ff <= {cs_sync_ff[0], select_load_strobe_i};
            sck_sync_ff <= {sck_sync_ff[0], shift_clk_i};
            din_sync_ff <= {din_sync_ff[0], serial_data_i};
        end
    end

    assign cs_s = cs_sync_ff[1];
    assign sck_s = sck_sync_ff[1];
    assign din_s = din_sync_ff[1];

    // Edge detection on synchronised levels
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cs_d_ff <= 1'b1;
            sck_d_ff <= 1'b0;
        end else begin
            cs_d_ff <= cs_s;
            sck_d_ff <= sck_s;
        end
    end

    assign sck_rise = sck_s && !sck_d_ff;
    assign cs_rise = cs_s && !cs_d_ff;
    assign cs_fall = !cs_s && cs_d_ff;

    // Link state: shifting only while strobe low
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (cs_fall) begin
                    nxt_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (cs_rise) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Shift in MSB first; older bits fall off the top
    assign nxt_shift = (state_ff == ST_SHIFT && !cs_s && sck_rise)
        ? {shift_ff[14:0], din_s} : shift_ff; // RL2 RL3 RL5 RL22
    assign link_exec = state_ff == ST_SHIFT && cs_rise; // RL4

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            shift_ff <= 16'h0000;
            bit_cnt_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            if (cs_fall) begin
                bit_cnt_ff <= 8'h00;
            end else if (nxt_shift != shift_ff || (state_ff == ST_SHIFT && sck_rise)) begin
                bit_cnt_ff <= (bit_cnt_ff == 8'hff) ? bit_cnt_ff : bit_cnt_ff + 8'h01;
            end
        end
    end

    // Software may also issue a word; the link wins when both arrive together
    assign sw_exec = sw_go_ff && !link_exec;
    assign exec = link_exec || sw_exec;
    assign exec_cmd = link_exec ? shift_ff[`CMD_HI:`CMD_LO]
        : sw_word_ff[`CMD_HI:`CMD_LO]; // RL1
    assign exec_code = link_exec ? shift_ff[`CODE_HI:`CODE_LO]
        : sw_word_ff[`CODE_HI:`CODE_LO]; // RL1

    dac_chan_regs u_regs (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .exec_i(exec),
        .cmd_i(exec_cmd),
        .code_i(exec_code),
        .in_a_o(in_a),
        .in_b_o(in_b),
        .out_a_o(out_a),
        .out_b_o(out_b),
        .sleep_o(sleep)
    );

    assign channel_a_output_o = out_a; // RL16
    assign channel_b_output_o = out_b;
    assign analog_disable_o = sleep; // RL11
    assign high_z_o = sleep; // RL13

    // Avalon slave: one wait cycle, then acknowledge
    assign bus_req = avs_read_i || avs_write_i;
    assign avs_waitrequest_o = bus_req && !ack_ff;
    assign avs_readdata_o = rd_data_ff;

    assign nxt_rd = (avs_address_i == `OFS_CTRL) ? {16'h0000, sw_word_ff}
        : (avs_address_i == `OFS_STATUS) ? {23'h0, bit_cnt_ff, sleep}
        : (avs_address_i == `OFS_IN_A) ? {22'h0, in_a}
        : (avs_address_i == `OFS_IN_B) ? {22'h0, in_b}
        : (avs_address_i == `OFS_OUT_A) ? {22'h0, out_a}
        : (avs_address_i == `OFS_OUT_B) ? {22'h0, out_b}
        : (avs_address_i == `OFS_COUNT) ? {last_word_ff, word_count_ff}
        : `UNMAPPED_DATA;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ack_ff <= 1'b0;
            rd_data_ff <= 32'h00000000;
            sw_word_ff <= 16'h0000;
            sw_go_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req && !ack_ff;
            if (avs_read_i && !ack_ff) begin
                rd_data_ff <= nxt_rd;
            end
            if (sw_exec) begin
                sw_go_ff <= 1'b0;
            end
            // A write lands only at the edge that sees waitrequest low
            if (avs_write_i && ack_ff && avs_address_i == `OFS_CTRL) begin
                sw_word_ff <= avs_writedata_i[15:0];
                sw_go_ff <= 1'b1;
            end
        end
    end

    // Log of executed link words
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            last_word_ff <= 16'h0000;
            word_count_ff <= 16'h0000;
        end else if (link_exec) begin
            last_word_ff <= shift_ff;
            word_count_ff <= word_count_ff + 16'h0001;
        end
    end

    chk_hold_when_high: assert property (@(posedge clk_i) disable iff (reset_i) // RL5
        (cs_s && cs_d_ff) |=> $stable(shift_ff))
        else $error("shift register moved while strobe high");
    chk_shift_on_edge: assert property (@(posedge clk_i) disable iff (reset_i) // RL2
        (state_ff == ST_SHIFT && !cs_s && sck_rise) |=> shift_ff[0] == $past(din_s)
        && shift_ff[15:1] == $past(shift_ff[14:0]))
        else $error("bit not shifted on rising shift clock");
    chk_exec_on_rise: assert property (@(posedge clk_i) disable iff (reset_i) // RL4
        link_exec |=> last_word_ff == $past(shift_ff))
        else $error("word not executed on strobe rise");
    chk_wait_bounded: assert property (@(posedge clk_i) disable iff (reset_i)
        bus_req |-> ##[0:1] !avs_waitrequest_o)
        else $error("bus request not answered in one cycle");
    // A software word runs one cycle after its write, two if the link wins
    chk_ctrl_write_exec: assert property (@(posedge clk_i) disable iff (reset_i)
        (avs_write_i && !avs_waitrequest_o && avs_address_i == `OFS_CTRL)
        |-> ##[1:2] sw_exec)
        else $error("software word not executed after its write");
endmodule : dac_serial_ctrl
